// ==== usb_fifo_cfg.svh ====
/*
 Register indices, bit positions, reset values and sizes of the FIFO block.
 Assumes: byte address is four times the index.
*/
`ifndef USB_FIFO_CFG_SVH
`define USB_FIFO_CFG_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_EP_SETUP 16'hff70
`define IDX_BULK_IN_DATA 16'hff71
`define IDX_BULK_OUT_DATA 16'hff72
`define IDX_EP0_WRITE_DATA 16'hff73
`define IDX_FIFO_STATUS 16'hff74
`define IDX_TRANSMIT_END 16'hff75
`define IDX_IN_FLUSH 16'hff79
`define IDX_OUT_FLUSH 16'hff7a

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define OUT_FLUSH_CPU 0
`define OUT_FLUSH_BOTH 1
`define IN_FLUSH_EP0_WRITE 1
`define IN_FLUSH_BULK_CPU 4
`define END_EP0 0
`define END_BULK_IN 1
`define SETUP_IN_EN 0
`define SETUP_OUT_EN 1
`define SETUP_CONFIGURED 2
`define SETUP_EP0_STAT1 3
`define SETUP_OUT_NAK 4

// ----------------------------------------------------------------
// Resets, sizes, answers
// ----------------------------------------------------------------
`define SETUP_RESET 4'h0
`define END_KEEP_RESET 2'h0
`define BULK_DEPTH 7'h40
`define EP0_DEPTH 7'h08
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== usb_fifo_pkg.sv ====
/*
 Types of the FIFO control block.
 Assumes: nothing.
*/
package usb_fifo_pkg;

   typedef enum logic [1:0] {
      EP_ZERO = 2'b00,
      EP_BULK_IN = 2'b01
   } ep_select_type;

   typedef struct packed {
      ep_select_type ep;
      logic [6:0] len;
   } tx_req_type;

endpackage

// ==== tx_req_if.sv ====
/*
 Transmit request carrier.
 Assumes: one clock for both ends.
*/
`timescale 1ns/1ps
interface tx_req_if;
   import usb_fifo_pkg::*;
   logic valid;
   logic ready;
   tx_req_type req;
   modport src (output valid, output req, input ready);
   modport dst (input valid, input req, output ready);
endinterface

// ==== byte_counter.sv ====
/*
 Byte counter of one FIFO half.
 Assumes: synchronous reset on aclk.
*/
`timescale 1ns/1ps
module byte_counter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic load,
   input wire logic [6:0] load_value,
   input wire logic inc,
   input wire logic dec,
   output logic [6:0] count
);

   // A byte arriving while clearing is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 7'h00;
      end else if (clear) begin
         count <= {6'h00, inc};
      end else if (load) begin
         count <= load_value;
      end else if (inc && !dec) begin
         count <= count + 7'h01;
      end else if (dec && !inc) begin
         count <= count - 7'h01;
      end
   end

endmodule

// ==== tx_request_buffer.sv ====
/*
 Two-entry transmit request buffer.
 Assumes: out_ready may stall for any time.
*/
`timescale 1ns/1ps
module tx_request_buffer
   import usb_fifo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   tx_req_if.dst in_side,
   output logic out_valid,
   input wire logic out_ready,
   output tx_req_type out_req
);

   tx_req_type entry_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign in_side.ready = (count_reg != 2'h2);
   assign push = in_side.valid && in_side.ready;
   assign out_valid = (count_reg != 2'h0);
   assign pop = out_valid && out_ready;
   assign out_req = entry_reg[rd_ptr_reg];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         entry_reg[0] <= '0;
         entry_reg[1] <= '0;
      end else if (push) begin
         entry_reg[wr_ptr_reg] <= in_side.req;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= 2'h0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 2'h1;
      end
   end

endmodule

// ==== usb_fifo_ctrl.sv ====
/*
 FIFO clear and transmit-end control of a USB function.
 AXI4-Lite register slave; requests go to the engine.
 Assumes: one-cycle done pulse per IN packet;
 inputs synchronous to aclk.
*/
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "usb_fifo_cfg.svh"

// What this block does
// RQ1: Bulk-out flush register always reads zero.
// RQ2: Writing one flushes the chosen FIFO; the bit never stays set.
// RQ3: Zero bits written to flush or end registers do nothing.
// RQ4: Flush and end bits ignored for unsupported or unconfigured endpoints.
// RQ5: Bit 1 of bulk-out flush empties both halves and their counters.
// RQ6: Bit 0 of bulk-out flush empties only the CPU half.
// RQ7: Bulk-out flush drops the NAK flag unless firmware set it.
// RQ8: Writing one to an end bit starts transfer; bit self-clears.
// RQ9: End register reads zero except bits 7 and 6, plain storage.
// RQ10: Bulk-in end swaps buffer soon, sets bulk-in NAK, sends data.
// RQ11: Bulk-in end with zero count sends a zero-length packet.
// RQ12: Bulk-in end with bytes and not full sends a short packet.
// RQ13: Full CPU-side bulk-in buffer starts sending without any strobe.
// RQ14: Endpoint-0 end sets write NAK flag and sends the write buffer.
// RQ15: Endpoint-0 end, zero count and status bit 1 sends null packet.
// RQ16: Endpoint-0 end, bytes, status bit 1, not full sends short packet.
// RQ17: Firmware strobes bulk-in end only after writing all its bytes.
// RQ18: Endpoint-0 write flush empties that buffer and resets its counter.
// RQ19: Both bulk-out flush bits together mean a full flush, one write.
module usb_fifo_ctrl
   import usb_fifo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [17:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [17:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rx_byte_valid,
   output logic rx_byte_ready,
   input wire logic rx_packet_end,
   output logic tx_valid,
   input wire logic tx_ready,
   output ep_select_type tx_endpoint,
   output logic [6:0] tx_length,
   input wire logic tx_done_bulk_in,
   input wire logic tx_done_ep0,
   output logic bulk_out_nak_flag,
   output logic bulk_in_nak_flag,
   output logic ep_zero_write_nak_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic aw_held_reg;
   logic [17:0] awaddr_reg;
   logic w_held_reg;
   logic [7:0] wbyte_reg;
   logic wlane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rd_word;
   logic rd_hit;
   logic rd_take;
   logic wr_fire;
   logic wr_hit;
   logic wr_byte;
   logic [15:0] wr_idx;
   logic [3:0] setup_reg;
   logic [1:0] end_keep_reg;
   logic in_ok;
   logic out_ok;
   logic wr_setup;
   logic flush_out_cpu;
   logic flush_out_both;
   logic flush_out_any;
   logic bi_flush;
   logic ep0_flush;
   logic end_bulk;
   logic end_ep0;
   logic bi_push;
   logic ep0_push;
   logic bo_pop;
   logic [6:0] bo_sie_cnt;
   logic [6:0] bo_cpu_cnt;
   logic [6:0] bi_cnt;
   logic [6:0] ep0_cnt;
   logic bo_pkt_reg;
   logic pkt_end_take;
   logic bo_toggle;
   logic bo_nak_reg;
   logic bo_nak_fw_reg;
   logic bi_nak_reg;
   logic ep0_nak_reg;
   logic bi_pend_reg;
   logic ep0_pend_reg;
   logic bi_want;
   logic ep0_want;
   logic bi_go;
   logic ep0_go;
   tx_req_type tx_out;

   tx_req_if txq ();

   function automatic logic is_mapped(input logic [15:0] idx);
      case (idx)
         `IDX_EP_SETUP, `IDX_BULK_IN_DATA, `IDX_BULK_OUT_DATA,
         `IDX_EP0_WRITE_DATA, `IDX_FIFO_STATUS, `IDX_TRANSMIT_END,
         `IDX_IN_FLUSH, `IDX_OUT_FLUSH: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------------------------------
   // Either of address and data may come first
   assign awready = !aw_held_reg;
   assign wready = !w_held_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= 18'h00000;
      end else if (awvalid && awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg <= awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
      end else if (wvalid && wready) begin
         w_held_reg <= 1'b1;
         wbyte_reg <= wdata[7:0];
         wlane_reg <= wstrb[0];
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign wr_idx = awaddr_reg[17:2];
   assign wr_hit = is_mapped(wr_idx) && (awaddr_reg[1:0] == 2'h0);
   assign wr_byte = wr_fire && wr_hit && wlane_reg;

   // ----------------------------------------------------------------
   // AXI4-Lite read channels
   // ----------------------------------------------------------------
   assign arready = !rvalid_reg;
   assign rd_take = arvalid && arready;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   always_comb begin
      rd_word = 32'h00000000;
      case (araddr[17:2])
         `IDX_EP_SETUP: rd_word = {27'h0000000, bo_nak_fw_reg, setup_reg};
         `IDX_FIFO_STATUS: rd_word = {1'b0, ep0_cnt, 1'b0, bi_cnt, 1'b0,
            bo_cpu_cnt, 5'h00, ep0_nak_reg, bi_nak_reg, bo_nak_reg};
         `IDX_TRANSMIT_END: rd_word = {24'h000000, end_keep_reg, 6'h00}; // [RQ9]
         default: rd_word = 32'h00000000; // [RQ1]
      endcase
   end

   assign rd_hit = is_mapped(araddr[17:2]) && (araddr[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_hit ? rd_word : 32'h00000000;
         rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Setup and end-register storage
   // ----------------------------------------------------------------
   assign wr_setup = wr_byte && (wr_idx == `IDX_EP_SETUP);
   assign in_ok = setup_reg[`SETUP_IN_EN] && setup_reg[`SETUP_CONFIGURED];
   assign out_ok = setup_reg[`SETUP_OUT_EN] && setup_reg[`SETUP_CONFIGURED];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setup_reg <= `SETUP_RESET;
      end else if (wr_setup) begin
         setup_reg <= wbyte_reg[3:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         end_keep_reg <= `END_KEEP_RESET;
      end else if (wr_byte && (wr_idx == `IDX_TRANSMIT_END)) begin
         end_keep_reg <= wbyte_reg[7:6]; // [RQ9]
      end
   end

   // ----------------------------------------------------------------
   // Write and read decode: one-cycle strobes, never stored
   // ----------------------------------------------------------------
   // One in the bit and a supported endpoint
   assign flush_out_cpu = wr_byte && (wr_idx == `IDX_OUT_FLUSH) && out_ok &&
      wbyte_reg[`OUT_FLUSH_CPU]; // [RQ2] [RQ3] [RQ4] [RQ6]
   assign flush_out_both = wr_byte && (wr_idx == `IDX_OUT_FLUSH) && out_ok &&
      wbyte_reg[`OUT_FLUSH_BOTH]; // [RQ2] [RQ3] [RQ4] [RQ5]
   assign flush_out_any = flush_out_cpu || flush_out_both;
   assign bi_flush = wr_byte && (wr_idx == `IDX_IN_FLUSH) && in_ok &&
      wbyte_reg[`IN_FLUSH_BULK_CPU]; // [RQ3] [RQ4]
   assign ep0_flush = wr_byte && (wr_idx == `IDX_IN_FLUSH) &&
      wbyte_reg[`IN_FLUSH_EP0_WRITE]; // [RQ18]
   assign end_bulk = wr_byte && (wr_idx == `IDX_TRANSMIT_END) && in_ok &&
      wbyte_reg[`END_BULK_IN]; // [RQ8] [RQ3] [RQ4]
   // Needs status bit 1
   assign end_ep0 = wr_byte && (wr_idx == `IDX_TRANSMIT_END) &&
      wbyte_reg[`END_EP0] && setup_reg[`SETUP_EP0_STAT1]; // [RQ8] [RQ15]
   assign bi_push = wr_byte && (wr_idx == `IDX_BULK_IN_DATA) && in_ok &&
      (bi_cnt != `BULK_DEPTH);
   assign ep0_push = wr_byte && (wr_idx == `IDX_EP0_WRITE_DATA) &&
      (ep0_cnt != `EP0_DEPTH);
   assign bo_pop = rd_take && rd_hit && out_ok && (bo_cpu_cnt != 7'h00) &&
      (araddr[17:2] == `IDX_BULK_OUT_DATA);

   // ----------------------------------------------------------------
   // Bulk-out FIFO halves
   // ----------------------------------------------------------------
   // Engine half refuses bytes while holding a packet
   assign rx_byte_ready = out_ok && !bo_pkt_reg &&
      (bo_sie_cnt != `BULK_DEPTH);
   assign pkt_end_take = rx_packet_end && out_ok && !bo_pkt_reg;
   assign bo_toggle = bo_pkt_reg && (bo_cpu_cnt == 7'h00) && !flush_out_any;

   byte_counter bo_sie_half (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(flush_out_both || bo_toggle), // [RQ5] [RQ19]
      .load(1'b0),
      .load_value(7'h00),
      .inc(rx_byte_valid && rx_byte_ready),
      .dec(1'b0),
      .count(bo_sie_cnt)
   );

   byte_counter bo_cpu_half (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(flush_out_any), // [RQ5] [RQ6] [RQ19]
      .load(bo_toggle),
      .load_value(bo_sie_cnt),
      .inc(1'b0),
      .dec(bo_pop),
      .count(bo_cpu_cnt)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bo_pkt_reg <= 1'b0;
      end else if (pkt_end_take) begin
         bo_pkt_reg <= 1'b1;
      end else if (flush_out_both || bo_toggle) begin
         bo_pkt_reg <= 1'b0; // [RQ5]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bo_nak_fw_reg <= 1'b0;
      end else if (wr_setup) begin
         bo_nak_fw_reg <= wbyte_reg[`SETUP_OUT_NAK];
      end
   end

   // Packet beside an unread CPU half sets NAK
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bo_nak_reg <= 1'b0;
      end else if (pkt_end_take && (bo_cpu_cnt != 7'h00)) begin
         bo_nak_reg <= 1'b1;
      end else if (wr_setup) begin
         bo_nak_reg <= wbyte_reg[`SETUP_OUT_NAK];
      end else if ((flush_out_any || bo_toggle) && !bo_nak_fw_reg) begin
         bo_nak_reg <= 1'b0; // [RQ7]
      end
   end

   // ----------------------------------------------------------------
   // Bulk-in CPU half and endpoint-0 write buffer
   // ----------------------------------------------------------------
   byte_counter bi_cpu_half (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(bi_flush || bi_go), // [RQ10]
      .load(1'b0),
      .load_value(7'h00),
      .inc(bi_push),
      .dec(1'b0),
      .count(bi_cnt)
   );

   byte_counter ep0_write_half (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(ep0_flush || ep0_go), // [RQ18]
      .load(1'b0),
      .load_value(7'h00),
      .inc(ep0_push),
      .dec(1'b0),
      .count(ep0_cnt)
   );

   // ----------------------------------------------------------------
   // Transmit launch
   // ----------------------------------------------------------------
   // Waits while a packet is still in flight
   assign bi_want = (bi_pend_reg || (bi_cnt == `BULK_DEPTH)) && in_ok &&
      !bi_nak_reg && !bi_flush; // [RQ10] [RQ13]
   assign ep0_want = ep0_pend_reg && !ep0_nak_reg && !ep0_flush;
   // Endpoint 0 first: control must not wait behind bulk
   assign ep0_go = ep0_want && txq.ready; // [RQ14]
   assign bi_go = bi_want && txq.ready && !ep0_want;
   assign txq.valid = ep0_want || bi_want;

   // Zero buffered bytes give a null packet
   always_comb begin
      if (ep0_want) begin
         txq.req = '{ep: EP_ZERO, len: ep0_cnt}; // [RQ15] [RQ16]
      end else begin
         txq.req = '{ep: EP_BULK_IN, len: bi_cnt}; // [RQ11] [RQ12]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bi_pend_reg <= 1'b0;
      end else if (end_bulk) begin
         bi_pend_reg <= 1'b1; // [RQ8] [RQ10]
      end else if (bi_go) begin
         bi_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_pend_reg <= 1'b0;
      end else if (end_ep0) begin
         ep0_pend_reg <= 1'b1; // [RQ8] [RQ14]
      end else if (ep0_go || ep0_flush) begin
         ep0_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bi_nak_reg <= 1'b0;
      end else if (bi_go) begin
         bi_nak_reg <= 1'b1; // [RQ10]
      end else if (tx_done_bulk_in) begin
         bi_nak_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_nak_reg <= 1'b0;
      end else if (ep0_go) begin
         ep0_nak_reg <= 1'b1; // [RQ14]
      end else if (tx_done_ep0 || ep0_flush) begin
         ep0_nak_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Request buffer toward the engine and flag outputs
   // ----------------------------------------------------------------
   tx_request_buffer tx_queue (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_side(txq.dst),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_req(tx_out)
   );

   assign tx_endpoint = tx_out.ep;
   assign tx_length = tx_out.len;
   assign bulk_out_nak_flag = bo_nak_reg;
   assign bulk_in_nak_flag = bi_nak_reg;
   assign ep_zero_write_nak_flag = ep0_nak_reg;

endmodule

// ==== usb_fifo_ctrl_checker.sv ====
/*
 Port checker of the FIFO control block.
 Assumes: bound to usb_fifo_ctrl; one clock.
*/
`timescale 1ns/1ps
`include "usb_fifo_cfg.svh"
module usb_fifo_ctrl_checker
   import usb_fifo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [17:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire ep_select_type tx_endpoint,
   input wire logic [6:0] tx_length,
   input wire logic tx_done_bulk_in,
   input wire logic tx_done_ep0,
   input wire logic bulk_in_nak_flag,
   input wire logic ep_zero_write_nak_flag
);
   logic [17:0] ra_reg;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Address of the read being answered
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (arvalid && arready) begin
         ra_reg <= araddr;
      end
   end
   flush_reads_zero_a:
      assert property (rvalid && ra_reg == {`IDX_OUT_FLUSH, 2'b00}
         |-> rdata == 32'h0) else $error("flush read nonzero");
   end_read_mask_a:
      assert property (rvalid && ra_reg == {`IDX_TRANSMIT_END, 2'b00}
         |-> rdata[31:8] == 24'h0 && rdata[5:0] == 6'h0)
         else $error("strobe read back");
   tx_request_held_a:
      assert property (tx_valid && !tx_ready |=> tx_valid
         && $stable(tx_length) && $stable(tx_endpoint))
         else $error("request changed");
   bulk_launch_a:
      assert property ($rose(bulk_in_nak_flag) |-> tx_valid)
         else $error("no bulk request");
   ep0_launch_a:
      assert property ($rose(ep_zero_write_nak_flag) |-> tx_valid)
         else $error("no ep0 request");
   bulk_nak_clear_a:
      assert property (tx_done_bulk_in |=> !bulk_in_nak_flag)
         else $error("bulk flag kept");
   ep0_nak_clear_a:
      assert property (tx_done_ep0 |=> !ep_zero_write_nak_flag)
         else $error("ep0 flag kept");
   tx_length_bound_a:
      assert property (tx_valid |-> tx_length <= (tx_endpoint == EP_ZERO
         ? `EP0_DEPTH : `BULK_DEPTH)) else $error("packet too long");
endmodule

bind usb_fifo_ctrl usb_fifo_ctrl_checker usb_fifo_ctrl_checker_inst (
   .aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rvalid,
   .tx_valid, .tx_ready, .tx_endpoint, .tx_length, .tx_done_bulk_in,
   .tx_done_ep0, .bulk_in_nak_flag, .ep_zero_write_nak_flag
);

// ==== sie_model.sv ====
/*
 Engine model: takes requests, stalls at random, pulses done, feeds packets.
 Assumes: shares aclk with the block.
*/
`timescale 1ns/1ps
module sie_model
   import usb_fifo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stall,
   input wire logic tx_valid,
   input wire ep_select_type tx_endpoint,
   output logic tx_ready,
   output logic tx_done_bulk_in,
   output logic tx_done_ep0,
   output logic rx_byte_valid,
   input wire logic rx_byte_ready,
   output logic rx_packet_end
);
   logic [2:0] bin_cnt, ep0_cnt;
   logic took, took_ep0;
   initial begin
      {tx_ready, tx_done_bulk_in, tx_done_ep0, rx_byte_valid} = 4'h0;
      {rx_packet_end, bin_cnt, ep0_cnt} = 7'h0;
   end
   // Mid-cycle sample
   always @(negedge aclk) begin
      took = tx_valid && tx_ready;
      took_ep0 = tx_endpoint == EP_ZERO;
   end
   // Done pulse a few cycles after taking
   always @(posedge aclk) begin
      tx_ready <= aresetn && (!stall || $urandom_range(3) == 0);
      tx_done_bulk_in <= bin_cnt == 3'h1;
      tx_done_ep0 <= ep0_cnt == 3'h1;
      if (bin_cnt != 3'h0) bin_cnt <= bin_cnt - 3'h1;
      if (ep0_cnt != 3'h0) ep0_cnt <= ep0_cnt - 3'h1;
      if (took && took_ep0) ep0_cnt <= 3'h5;
      if (took && !took_ep0) bin_cnt <= 3'h5;
   end
   task rx_pkt(input int n);
      int k;
      @(posedge aclk);
      rx_byte_valid <= 1'b1;
      for (k = 0; k < 200 && n > 0; k++) begin
         @(negedge aclk);
         if (rx_byte_ready) n--;
         @(posedge aclk);
         if (n == 0) rx_byte_valid <= 1'b0;
      end
      rx_packet_end <= 1'b1;
      @(posedge aclk);
      rx_packet_end <= 1'b0;
   endtask
endmodule

// ==== usb_fifo_ctrl_tb_top.sv ====
/*
 Self-checking bench of the FIFO control block.
 Assumes: sie_model plays the engine.
*/
`timescale 1ns/1ps
`include "usb_fifo_cfg.svh"
module usb_fifo_ctrl_tb_top;
   import usb_fifo_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rx_byte_valid, rx_byte_ready;
   logic rx_packet_end, tx_valid, tx_ready, tx_done_bulk_in, tx_done_ep0;
   logic bulk_out_nak_flag, bulk_in_nak_flag, ep_zero_write_nak_flag, stall;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [6:0] tx_length;
   ep_select_type tx_endpoint;
   logic [33:0] rq[$];
   logic [8:0] tq[$];
   int miscompares = 0;
   int n_checks = 0;
   int i;
   usb_fifo_ctrl usb_fifo_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .rx_byte_valid, .rx_byte_ready, .rx_packet_end, .tx_valid, .tx_ready,
      .tx_endpoint, .tx_length, .tx_done_bulk_in, .tx_done_ep0,
      .bulk_out_nak_flag, .bulk_in_nak_flag, .ep_zero_write_nak_flag);
   sie_model sie_model_inst (.aclk, .aresetn, .stall, .tx_valid,
      .tx_endpoint, .tx_ready, .tx_done_bulk_in, .tx_done_ep0,
      .rx_byte_valid, .rx_byte_ready, .rx_packet_end);
   always #50 aclk = ~aclk;
   task chk(input logic [33:0] s, input logic [33:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task print_verdict;
      miscompares += rq.size() + tq.size();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task hang;
      miscompares++;
      print_verdict();
   endtask
   // ------------------------------------------------------------
   // Bus master
   // ------------------------------------------------------------
   task wr(input logic [15:0] idx, input logic [7:0] d);
      int k;
      logic a, w, b;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (k = 0; k < 40; k++) begin
         @(negedge aclk);
         {a, w, b} = {awready, wready, bvalid};
         @(posedge aclk);
         {awvalid, wvalid, bready} <= {awvalid && !a, wvalid && !w, !b};
         if (b) break;
      end
      if (k == 40) hang();
   endtask
   task rd(input logic [15:0] idx, input logic [33:0] e);
      int k;
      logic a, r;
      rq.push_back(e);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'h3;
      for (k = 0; k < 40; k++) begin
         @(negedge aclk);
         {a, r} = {arready, rvalid};
         @(posedge aclk);
         {arvalid, rready} <= {arvalid && !a, !r};
         if (r) break;
      end
      if (k == 40) hang();
   endtask
   // Drain packets so request order stays fixed
   task settle;
      int k;
      for (k = 0; k < 400 && (tq.size() != 0 || bulk_in_nak_flag
         || ep_zero_write_nak_flag); k++) @(negedge aclk);
      if (k == 400) hang();
      @(posedge aclk);
      stall <= 1'($urandom);
   endtask
   // ------------------------------------------------------------
   // Result watcher
   // ------------------------------------------------------------
   always @(negedge aclk) begin
      if (rvalid && rready)
         chk({rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
      if (tx_valid && tx_ready)
         chk({tx_endpoint, tx_length}, tq.size() ? tq.pop_front() : 'x);
   end
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata, stall} = 69'h0;
      wstrb = 4'h1;
      void'($urandom(39838));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`IDX_EP_SETUP, 8'h0f);
      rd(`IDX_TRANSMIT_END, 34'h0);
      rd(16'h0000, {`RESP_DECERR, 32'h0});
      wr(`IDX_OUT_FLUSH, 8'hff);
      rd(`IDX_OUT_FLUSH, 34'h0);
      sie_model_inst.rx_pkt(5);
      sie_model_inst.rx_pkt(4);
      rd(`IDX_FIFO_STATUS, 34'h501);
      chk(bulk_out_nak_flag, 34'h1);
      wr(`IDX_OUT_FLUSH, 8'h01);
      rd(`IDX_FIFO_STATUS, 34'h400);
      wr(`IDX_OUT_FLUSH, 8'h01);
      for (i = 2; i < 4; i++) begin
         sie_model_inst.rx_pkt(2);
         sie_model_inst.rx_pkt(3);
         wr(`IDX_OUT_FLUSH, 8'(i));
         rd(`IDX_FIFO_STATUS, 34'h0);
      end
      wr(`IDX_EP_SETUP, 8'h1f);
      wr(`IDX_OUT_FLUSH, 8'h01);
      rd(`IDX_FIFO_STATUS, 34'h1);
      wr(`IDX_EP_SETUP, 8'h0f);
      settle();
      tq.push_back({EP_BULK_IN, 7'd0});
      wr(`IDX_TRANSMIT_END, 8'h02);
      settle();
      repeat (3) wr(`IDX_BULK_IN_DATA, 8'($urandom));
      tq.push_back({EP_BULK_IN, 7'd3});
      wr(`IDX_TRANSMIT_END, 8'h02);
      settle();
      repeat (63) wr(`IDX_BULK_IN_DATA, 8'($urandom));
      tq.push_back({EP_BULK_IN, 7'd64});
      wr(`IDX_BULK_IN_DATA, 8'($urandom));
      settle();
      repeat (2) wr(`IDX_EP0_WRITE_DATA, 8'($urandom));
      tq.push_back({EP_ZERO, 7'd2});
      wr(`IDX_TRANSMIT_END, 8'h01);
      settle();
      wr(`IDX_EP0_WRITE_DATA, 8'($urandom));
      wr(`IDX_IN_FLUSH, 8'h02);
      tq.push_back({EP_ZERO, 7'd0});
      wr(`IDX_TRANSMIT_END, 8'h01);
      settle();
      wr(`IDX_TRANSMIT_END, 8'h00);
      wr(`IDX_OUT_FLUSH, 8'h00);
      wr(`IDX_EP_SETUP, 8'h00);
      wr(`IDX_TRANSMIT_END, 8'h03);
      wr(`IDX_EP_SETUP, 8'h07);
      wr(`IDX_TRANSMIT_END, 8'h01);
      wr(`IDX_EP_SETUP, 8'h0f);
      tq.push_back({EP_BULK_IN, 7'd0});
      wr(`IDX_TRANSMIT_END, 8'hc2);
      rd(`IDX_TRANSMIT_END, 34'hc0);
      wr(`IDX_TRANSMIT_END, 8'h00);
      rd(`IDX_TRANSMIT_END, 34'h0);
      settle();
      print_verdict();
   end
endmodule
